// ===== asq_pkg.sv
/*
 * constants for the converter sequencer and result transfer unit:
 * register offsets, control and status field positions, reset values,
 * sample and conversion cycle counts, modes and sequencer states.
 * assumes a 32-bit AXI4-Lite register bus and word-aligned offsets.
 */
package asq_pkg;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_RES = 8'h08;
   localparam logic [7:0] OFF_CNT = 8'h0C;
   localparam logic [7:0] OFF_SA = 8'h10;
   // control field positions
   localparam int C_EN = 0;
   localparam int C_SW = 1;
   localparam int C_SRC = 2;
   localparam int C_INV = 4;
   localparam int C_SHT = 5;
   localparam int C_MODE = 7;
   localparam int C_MSC = 9;
   localparam int C_CH = 10;
   localparam int C_DIV = 14;
   localparam int C_TB = 17;
   // status field positions
   localparam int S_BUSY = 0;
   localparam int S_DONE = 1;
   localparam int S_B1 = 2;
   localparam int S_DTC = 3;
   localparam int S_CH = 4;
   // ***************************************************
   // reset values and timing counts
   // ***************************************************
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [15:0] SA_RST = 16'h0200;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [6:0] SMP_CYC0 = 7'h04;
   localparam logic [6:0] SMP_CYC1 = 7'h08;
   localparam logic [6:0] SMP_CYC2 = 7'h10;
   localparam logic [6:0] SMP_CYC3 = 7'h40;
   localparam logic [6:0] CONV_CYC = 7'h0B;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   // conversion modes
   localparam logic [1:0] M_SINGLE = 2'b00;
   localparam logic [1:0] M_SEQ = 2'b01;
   localparam logic [1:0] M_REP = 2'b10;
   localparam logic [1:0] M_REPSEQ = 2'b11;
   // sequencer states
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SAMP = 2'b01, ST_CONV = 2'b11} asq_state_t;
endpackage

// ===== asq_core.sv
/*
 * converter sequencer with trigger select, sample timer, conversion
 * timer, four conversion modes and a one/two block result transfer unit.
 * assumes: sar_data is stable from the analog core on aclk, timer
 * compare inputs are asynchronous, the memory bus accepts one write.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Function
// - trigger rising edge, selectable source, invertible
// - sample period 4, 8, 16 or 64
// - sampling active exactly the sample period
// - sampling end starts 11-cycle conversion
// - two-bit field selects four modes
// - single mode, retrigger or enable toggle
// - sequence steps down, stops after zero
// - repeat mode converts one channel forever
// - repeat sequence restarts on next trigger, at once if multi-conversion bit set
// - auto conversions ignore further trigger edges
// - single mode enable clear aborts immediately
// - repeat single stops after current conversion
// - sequence modes stop at sequence end
// - mode zero plus enable clear halts
// - nonzero count enables one transfer per result
// - one transfer cycle halts processor once
// - one block spans start to 2n-2
// - pointer plus two, counter minus one
// - one block stops at zero, sets done
// - block one full, reload, fill block two
// - block two full clears block-one flag
// - enable needed; control fields locked while enabled, count and start address while busy
// - without transfers done sets per result
module asq_core
   import asq_pkg::*;
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte enables
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [2:0] timer_cmp, // async timer triggers
   input wire logic [9:0] sar_data, // converter result
   output logic sampling_active, // sample window
   output logic converting, // conversion running
   output logic [3:0] channel_out, // selected channel
   output logic result_load, // result loaded pulse
   output logic mem_we, // memory write pulse
   output logic [15:0] mem_addr, // memory byte address
   output logic [15:0] mem_wdata, // memory write word
   output logic cpu_halt // processor stall pulse
);
   // ***************************************************
   // declarations
   // ***************************************************
   asq_state_t state_q, state_d;
   logic [31:0] ctrl_q;
   logic sw_q, armed_q, seq_q, pend_q, trig_q;
   logic [2:0] t1_q, t2_q, dcnt_q;
   logic [6:0] cnt_q, cnt_d;
   logic [3:0] ch_q, ch_d;
   logic [9:0] res_q;
   logic load_q;
   logic [7:0] ncnt_q, tc_q;
   logic [15:0] sa_q, ptr_q, addr_q, mwd_q;
   logic blk2_q, b1_q, stop_q, done_q, init_q, we_q;
   logic aw_h_q, w_h_q, bv_q, rv_q;
   logic [7:0] wa_q;
   logic [31:0] wd_q, rd_q;
   logic [3:0] ws_q;
   logic [1:0] br_q, rr_q;

   // byte-lane merge of a bus write
   function automatic logic [31:0] asq_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
         begin
            r[i*8+:8] = n[i*8+:8];
         end
      end
      return r;
   endfunction

   // ***************************************************
   // register bus decode
   // ***************************************************
   wire wr_fire = aw_h_q & w_h_q & ~bv_q;
   wire wr_ctrl = wr_fire & (wa_q == OFF_CTRL);
   wire wr_stat = wr_fire & (wa_q == OFF_STAT);
   wire wr_cnt = wr_fire & (wa_q == OFF_CNT);
   wire wr_sa = wr_fire & (wa_q == OFF_SA);
   wire wr_hit = wr_ctrl | wr_stat | wr_cnt | wr_sa | (wr_fire & (wa_q == OFF_RES));
   wire ar_fire = arvalid & ~rv_q;
   wire [31:0] wmerge = asq_merge(ctrl_q, wd_q, ws_q);
   // start address merge; only the low half is a register
   wire [31:0] sa_merge = asq_merge({16'h0000, sa_q}, wd_q, ws_q);
   wire [31:0] stat_v;
   wire ar_hit = (araddr == OFF_CTRL) | (araddr == OFF_STAT) | (araddr == OFF_RES) |
                 (araddr == OFF_CNT) | (araddr == OFF_SA);
   wire [31:0] rd_v = (araddr == OFF_CTRL) ? ctrl_q :
                      (araddr == OFF_STAT) ? stat_v :
                      (araddr == OFF_RES) ? {22'h0, res_q} :
                      (araddr == OFF_CNT) ? {24'h000000, ncnt_q} :
                      (araddr == OFF_SA) ? {16'h0000, sa_q} : 32'h00000000;
   assign awready = ~aw_h_q & ~bv_q;
   assign wready = ~w_h_q & ~bv_q;
   assign arready = ~rv_q;
   assign bvalid = bv_q;
   assign bresp = br_q;
   assign rvalid = rv_q;
   assign rdata = rd_q;
   assign rresp = rr_q;

   // write channel capture, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_h_q <= 1'b0;
         w_h_q <= 1'b0;
         bv_q <= 1'b0;
         br_q <= RESP_OK;
         wa_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
      end
      else
      begin
         if (awvalid & awready)
         begin
            aw_h_q <= 1'b1;
            wa_q <= awaddr;
         end
         if (wvalid & wready)
         begin
            w_h_q <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
         end
         if (wr_fire)
         begin
            aw_h_q <= 1'b0;
            w_h_q <= 1'b0;
            bv_q <= 1'b1;
            br_q <= wr_hit ? RESP_OK : RESP_ERR;
         end
         else if (bv_q & bready)
         begin
            bv_q <= 1'b0;
         end
      end
   end

   // read channel, one cycle answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rv_q <= 1'b0;
         rd_q <= 32'h00000000;
         rr_q <= RESP_OK;
      end
      else if (ar_fire)
      begin
         rv_q <= 1'b1;
         rd_q <= rd_v;
         rr_q <= ar_hit ? RESP_OK : RESP_ERR;
      end
      else if (rv_q & rready)
      begin
         rv_q <= 1'b0;
      end
   end

   // ***************************************************
   // control fields and trigger path
   // ***************************************************
   wire en = ctrl_q[C_EN];
   wire [1:0] src = ctrl_q[C_SRC+:2];
   wire [1:0] sht = ctrl_q[C_SHT+:2];
   wire [1:0] mode = ctrl_q[C_MODE+:2];
   wire multi_conversion_bit = ctrl_q[C_MSC];
   wire [3:0] chsel = ctrl_q[C_CH+:4];
   wire [2:0] div = ctrl_q[C_DIV+:3];
   wire busy = (state_q != ST_IDLE) | seq_q;
   wire trig_raw = (src == 2'd0) ? sw_q : t2_q[src - 2'd1];
   wire trig = trig_raw ^ ctrl_q[C_INV];
   wire msc_run = multi_conversion_bit & (mode != M_SINGLE) & busy;
   wire edge_ok = trig & ~trig_q & ~msc_run;
   // conversion clock: aclk divided by div+1
   wire tick = (dcnt_q == div);
   wire abort = ~en & (mode == M_SINGLE);
   wire accept = tick & pend_q & ((en & armed_q) | seq_q) & (state_q == ST_IDLE) & ~abort;
   wire endc = (state_q == ST_CONV) & tick & (cnt_q == 7'h00) & ~abort;
   wire [6:0] smp = (sht == 2'd0) ? SMP_CYC0 : (sht == 2'd1) ? SMP_CYC1 :
                    (sht == 2'd2) ? SMP_CYC2 : SMP_CYC3;

   // control register; most fields locked while enabled
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= CTRL_RST;
      end
      else if (wr_ctrl)
      begin
         if (!en)
         begin
            ctrl_q <= {wmerge[31:2], 1'b0, wmerge[C_EN]};
         end
         else
         begin
            ctrl_q[C_EN] <= wmerge[C_EN];
            if (!wmerge[C_EN])
            begin
               ctrl_q[C_MODE+:2] <= wmerge[C_MODE+:2];
            end
         end
      end
   end

   // trigger synchronisers, edge latch, enable toggle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         t1_q <= 3'h0;
         t2_q <= 3'h0;
         trig_q <= 1'b0;
         pend_q <= 1'b0;
         sw_q <= 1'b0;
         armed_q <= 1'b0;
         dcnt_q <= 3'h0;
      end
      else
      begin
         t1_q <= timer_cmp;
         t2_q <= t1_q;
         trig_q <= trig;
         dcnt_q <= tick ? 3'h0 : dcnt_q + 3'h1;
         // edge waits for a tick; dropped while disabled unless a sequence is running (seq_q)
         pend_q <= ((pend_q & ~accept & ~abort) | edge_ok) & (en | seq_q);
         // convert bit self-clears once its sample begins
         sw_q <= (wr_ctrl & ws_q[0] & wd_q[C_SW]) | (sw_q & ~accept);
         if (!en)
         begin
            armed_q <= 1'b1;
         end
         else if (endc & (src != 2'd0) & ~mode[1] & (~mode[0] | (ch_q == 4'h0)))
         begin
            armed_q <= 1'b0;
         end
      end
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   wire last_ch = (ch_q == 4'h0);
   wire m_seq = mode[0];
   wire m_rep = mode[1];
   wire stop_c = (~m_seq & ~m_rep) | (m_seq & ~m_rep & last_ch) | (m_rep & ~en & (~m_seq | last_ch));
   wire auto_c = ~stop_c & multi_conversion_bit;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      ch_d = ch_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (accept)
            begin
               state_d = ST_SAMP;
               cnt_d = smp - 7'h01;
               ch_d = seq_q ? ch_q : chsel;
            end
         end
         ST_SAMP:
         begin
            if (tick)
            begin
               cnt_d = cnt_q - 7'h01;
               if (cnt_q == 7'h00)
               begin
                  state_d = ST_CONV;
                  cnt_d = CONV_CYC - 7'h01;
               end
            end
         end
         ST_CONV:
         begin
            if (tick)
            begin
               cnt_d = cnt_q - 7'h01;
               if (cnt_q == 7'h00)
               begin
                  state_d = auto_c ? ST_SAMP : ST_IDLE;
                  cnt_d = smp - 7'h01;
                  if (m_seq)
                  begin
                     ch_d = last_ch ? chsel : ch_q - 4'h1;
                  end
               end
            end
         end
      endcase
      if (abort)
      begin
         state_d = ST_IDLE;
      end
   end

   // state, counters and result register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 7'h00;
         ch_q <= 4'h0;
         seq_q <= 1'b0;
         res_q <= 10'h000;
         load_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ch_q <= ch_d;
         load_q <= endc;
         if (abort)
         begin
            seq_q <= 1'b0;
         end
         else if (endc)
         begin
            seq_q <= m_seq & ~last_ch;
         end
         if (endc)
         begin
            res_q <= sar_data;
         end
      end
   end

   assign sampling_active = (state_q == ST_SAMP);
   assign converting = (state_q == ST_CONV);
   assign channel_out = ch_q;
   assign result_load = load_q;

   // ***************************************************
   // result transfer unit
   // ***************************************************
   // active while count nonzero
   wire dtc_on = (ncnt_q != 8'h00);
   wire xfer = endc & dtc_on & ~stop_q & (tc_q != 8'h00) & ~init_q;
   wire blk_end = xfer & (tc_q == 8'h01);
   wire done_set = (endc & ~dtc_on) | blk_end;
   wire done_clr = wr_stat & ws_q[0] & wd_q[S_DONE];
   assign stat_v = {24'h000000, ch_q, dtc_on, b1_q, done_q, busy};

   // count and start address; config only while idle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ncnt_q <= CNT_RST;
         sa_q <= SA_RST;
         init_q <= 1'b0;
      end
      else
      begin
         init_q <= (wr_cnt | wr_sa) & ~busy;
         if (wr_cnt & ~busy & ws_q[0])
         begin
            ncnt_q <= wd_q[7:0];
         end
         if (wr_sa & ~busy)
         begin
            sa_q <= sa_merge[15:0];
         end
      end
   end

   // pointer, counter, block flags, memory write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ptr_q <= SA_RST;
         tc_q <= CNT_RST;
         blk2_q <= 1'b0;
         b1_q <= 1'b0;
         stop_q <= 1'b1;
         done_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 16'h0000;
         mwd_q <= 16'h0000;
      end
      else
      begin
         // set wins over software clear
         done_q <= done_set | (done_q & ~done_clr);
         // one cycle write, one cycle stall
         we_q <= xfer;
         if (init_q)
         begin
            ptr_q <= sa_q;
            tc_q <= ncnt_q;
            blk2_q <= 1'b0;
            stop_q <= 1'b0;
         end
         else if (xfer)
         begin
            addr_q <= ptr_q;
            mwd_q <= {6'h00, sar_data};
            ptr_q <= ptr_q + 16'h0002;
            tc_q <= tc_q - 8'h01;
            if (blk_end)
            begin
               if (ctrl_q[C_TB] & ~blk2_q)
               begin
                  // block one full, fill block two
                  blk2_q <= 1'b1;
                  b1_q <= 1'b1;
                  tc_q <= ncnt_q;
               end
               else
               begin
                  stop_q <= 1'b1;
                  blk2_q <= 1'b0;
                  b1_q <= 1'b0;
               end
            end
         end
      end
   end

   assign mem_we = we_q;
   assign cpu_halt = we_q;
   assign mem_addr = addr_q;
   assign mem_wdata = mwd_q;
endmodule

// ===== asq_mem_model.sv
/*
 * memory bus model for the result transfer unit: logs every write made under the stall.
 * assumes one write per cycle on aclk with byte addresses.
 */
`timescale 1ns/1ps
module asq_mem_model (
   input wire logic aclk, // system clock
   input wire logic mem_we, // write pulse
   input wire logic [15:0] mem_addr, // byte address
   input wire logic [15:0] mem_wdata, // write word
   input wire logic cpu_halt // stall pulse
);
   logic [15:0] addr_q[$];
   logic [15:0] data_q[$];
   // ***************************************************
   // write capture
   // ***************************************************
   // write under halt
   // a write without the stall would collide with the processor
   always @(posedge aclk)
      if (mem_we === 1'b1 && cpu_halt === 1'b1)
      begin
         addr_q.push_back(mem_addr);
         data_q.push_back(mem_wdata);
      end
endmodule

// ===== asq_core_monitor.sv
/*
 * assertion checker on the sequencer ports.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module asq_core_monitor
   import asq_pkg::*;
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // address valid
   input wire logic awready, // address ready
   input wire logic sampling_active, // sample window
   input wire logic converting, // conversion running
   input wire logic [3:0] channel_out, // channel
   input wire logic result_load, // result pulse
   input wire logic mem_we, // memory write
   input wire logic [15:0] mem_addr, // write address
   input wire logic [15:0] mem_wdata, // write word
   input wire logic cpu_halt // stall pulse
);
   // ***************************************************
   // helper: last transfer address
   // ***************************************************
   logic last_ok_q;
   logic [15:0] last_addr_q;
   wire logic cfg_wr = awvalid && awready && (awaddr == OFF_SA || awaddr == OFF_CNT);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a new start address restarts the pointer, so forget the old one
   always_ff @(posedge aclk)
      if (!aresetn || cfg_wr)
         last_ok_q <= 1'b0;
      else if (mem_we)
         last_ok_q <= 1'b1;
   always_ff @(posedge aclk)
      if (mem_we)
         last_addr_q <= mem_addr;
   // ***************************************************
   // properties
   // ***************************************************
   AST_SAMP_MIN: assert property ($rose(sampling_active) |-> sampling_active [*4])
      else $error("sample window too short");
   AST_SAMP_CONV: assert property ($fell(sampling_active) |-> converting)
      else $error("no conversion after sample");
   AST_LOAD_CONV: assert property (result_load |-> $past(converting))
      else $error("result without conversion");
   AST_LOAD_ONE: assert property (result_load |=> !result_load)
      else $error("result pulse too long");
   AST_HALT_ONE: assert property ((mem_we || cpu_halt) |-> (mem_we && cpu_halt) ##1 !cpu_halt)
      else $error("stall not one cycle with write");
   AST_WE_CAUSE: assert property (mem_we |-> result_load)
      else $error("write without result");
   AST_PTR_STEP: assert property (mem_we && last_ok_q |-> mem_addr == last_addr_q + 16'h0002)
      else $error("pointer step not two");
   AST_CH_HOLD: assert property (converting && $past(converting) |-> $stable(channel_out))
      else $error("channel moved in conversion");
   AST_DATA: assert property (mem_we |-> mem_wdata[15:10] == 6'h00)
      else $error("write word upper bits set");
endmodule
bind asq_core asq_core_monitor i_asq_core_monitor (.aclk, .aresetn, .awaddr, .awvalid, .awready,
   .sampling_active, .converting, .channel_out, .result_load, .mem_we, .mem_addr, .mem_wdata, .cpu_halt);

// ===== tb.sv
/*
 * self-checking bench for the sequencer: bus master, row tests,
 * then sequence, transfer, trigger, abort and stop tests.
 * assumes the core, checker and memory model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb
   import asq_pkg::*;
;
   typedef struct {logic [1:0] sht; logic [9:0] val; int smp;} asq_row_t;
   asq_row_t rows[4] = '{'{2'h0, 10'h3FF, 4}, '{2'h1, 10'h155, 8}, '{2'h2, 10'h2AA, 16}, '{2'h3, 10'h001, 64}};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic sampling_active, converting, result_load, mem_we, cpu_halt;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, c;
   logic [3:0] wstrb, channel_out;
   logic [1:0] bresp, rresp, r, b_last;
   logic [2:0] timer_cmp;
   logic [9:0] sar_data;
   logic [15:0] mem_addr, mem_wdata;
   logic [3:0] ch_q[$];
   int mismatches = 0, samples_checked = 0, cyc = 0, loads = 0, s_n = 0, c_n = 0, s_len, c_len, k, kc, w;
   asq_core i_asq_core (.*);
   asq_mem_model i_asq_mem_model (.*);
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // ***************************************************
   // window and result watcher, hang limit
   // ***************************************************
   always @(negedge aclk)
   begin
      s_n = sampling_active === 1'b1 ? s_n + 1 : 0;
      c_n = converting === 1'b1 ? c_n + 1 : 0;
      if (s_n == 1) ch_q.push_back(channel_out);
      if (s_n > 0) s_len = s_n;
      if (c_n > 0) c_len = c_n;
      if (result_load === 1'b1) loads++;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // each channel drops on its own handshake; readys sampled mid-cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [2:0] p;
      logic [2:0] h;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         p = 3'h7;
         while (p != 3'h0)
         begin
            @(negedge aclk);
            h = p & {awready, wready, bvalid};
            if (h[0]) b_last = bresp;
            @(posedge aclk);
            if (h[2]) awvalid <= 1'b0;
            if (h[1]) wvalid <= 1'b0;
            if (h[0]) bready <= 1'b0;
            p = p & ~h;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(negedge aclk); while (arready !== 1'b1);
         @(posedge aclk);
         arvalid <= 1'b0;
         do @(negedge aclk); while (rvalid !== 1'b1);
         v = rdata;
         e = rresp;
         @(posedge aclk);
         rready <= 1'b0;
      end
   endtask
   task automatic go(input logic [31:0] v);
      begin
         wr(OFF_CTRL, 32'h0);
         wr(OFF_CTRL, v & 32'hFFFFFFFC);
         wr(OFF_CTRL, v);
      end
   endtask
   task automatic wait_loads(input int n);
      int t;
      begin
         t = 0;
         while (loads < n && t < 400)
         begin
            @(negedge aclk);
            t++;
         end
         `CHK(loads >= n, 1'b1, "result missing")
      end
   endtask
   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      timer_cmp = 3'h0;
      sar_data = 10'h000;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_SA, d, r);
      `CHK(d[15:0], SA_RST, "start address reset")
      `CHK(r, RESP_OK, "read response")
      rd(8'h40, d, r);
      `CHK(r, RESP_ERR, "unmapped access")
      wr(8'h40, 32'h0);
      `CHK(b_last, RESP_ERR, "unmapped write")
      foreach (rows[i])
      begin
         sar_data <= rows[i].val;
         k = loads + 1;
         go(32'(rows[i].sht) << C_SHT | 32'h3);
         wait_loads(k);
         `CHK(s_len, rows[i].smp, "sample length")
         `CHK(c_len, 11, "conversion length")
         rd(OFF_RES, d, r);
         `CHK(d[9:0], rows[i].val, "result")
         rd(OFF_STAT, d, r);
         `CHK(d[S_DONE], 1'b1, "done per result")
         wr(OFF_STAT, 32'h2);
         rd(OFF_STAT, d, r);
         `CHK(d[S_DONE], 1'b0, "done clear")
      end
      `CHK(i_asq_mem_model.addr_q.size(), 0, "transfer with zero count")
      $display("row tests done");
      wr(OFF_CNT, 32'h3);
      `CHK(b_last, RESP_OK, "write response")
      wr(OFF_SA, 32'h0300);
      ch_q.delete();
      k = loads + 3;
      c = 32'(M_SEQ) << C_MODE | 32'h200 | 32'h2 << C_CH | 32'h3;
      go(c);
      wait_loads(k);
      for (int i = 0; i < 3; i++)
      begin
         `CHK(ch_q[i], 4'(2 - i), "sequence channel")
         `CHK(i_asq_mem_model.addr_q[i], 16'(16'h0300 + 2 * i), "block address")
         `CHK(i_asq_mem_model.data_q[i], {6'h00, rows[3].val}, "block data")
      end
      rd(OFF_STAT, d, r);
      `CHK(d[S_DONE], 1'b1, "block done")
      wr(OFF_CTRL, c);
      wait_loads(k + 3);
      `CHK(i_asq_mem_model.addr_q.size(), 3, "transfer after block")
      $display("sequence test done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT, 32'h2);
      wr(OFF_SA, 32'h0400);
      wr(OFF_STAT, 32'h2);
      i_asq_mem_model.addr_q.delete();
      c = c & ~(32'hF << C_CH) | 32'h1 << C_CH | 32'h1 << C_TB;
      k = loads + 2;
      go(c);
      wait_loads(k);
      rd(OFF_STAT, d, r);
      `CHK(d[S_B1], 1'b1, "block one full")
      wr(OFF_CTRL, c);
      wait_loads(k + 2);
      rd(OFF_STAT, d, r);
      `CHK(d[S_B1], 1'b0, "block two full")
      `CHK(i_asq_mem_model.addr_q[3], 16'h0406, "second block end")
      $display("two block test done");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT, 32'h0);
      for (int s = 1; s < 4; s++)
      begin
         timer_cmp <= 3'h7;
         k = loads;
         go(32'(s) << C_SRC | 32'h11);
         repeat (10) @(posedge aclk);
         `CHK(loads, k, "start before edge")
         timer_cmp[s - 1] <= 1'b0;
         wait_loads(k + 1);
      end
      $display("trigger test done");
      k = loads;
      go(32'h3 << C_SHT | 32'h3);
      w = 0;
      while (converting !== 1'b1 && w < 300)
      begin
         @(negedge aclk);
         w++;
      end
      wr(OFF_CTRL, 32'h0);
      @(negedge aclk);
      `CHK(converting, 1'b0, "abort")
      repeat (20) @(negedge aclk);
      `CHK(loads, k, "aborted result")
      c = 32'(M_REP) << C_MODE | 32'h200 | 32'h5 << C_CH | 32'h3;
      go(c);
      wait_loads(k + 2);
      wr(OFF_CTRL, c & 32'hFFFFFFFC);
      kc = loads;
      repeat (100) @(negedge aclk);
      `CHK(loads - kc <= 1, 1'b1, "repeat stop")
      `CHK(ch_q[$], 4'h5, "repeat channel")
      $display("stop test done");
      // reset in the middle of a long sample window
      go(32'h3 << C_SHT | 32'h3);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK(sampling_active, 1'b0, "reset window")
      rd(OFF_SA, d, r);
      `CHK(d[15:0], SA_RST, "start address after reset")
      $display("reset test done");
      tally_and_finish();
   end
endmodule
